//--- hdl/uart_regs_pkg.sv
package uart_regs_pkg;
  localparam int ADDR_W = 3;
  localparam logic [2:0] OFS_MODE = 3'h0;
  localparam logic [2:0] OFS_STAT = 3'h1;
  localparam logic [2:0] OFS_CMD = 3'h2;
  localparam logic [2:0] OFS_DATA = 3'h3;
  localparam logic [2:0] OFS_AUX = 3'h4;
  localparam logic [2:0] OFS_IMASK = 3'h5;
  localparam logic [2:0] OFS_CTHI = 3'h6;
  localparam logic [2:0] OFS_CTLO = 3'h7;
  localparam logic [3:0] CMD_PTR_RST = 4'h1;
  localparam logic [3:0] CMD_RX_RST = 4'h2;
  localparam logic [3:0] CMD_TX_RST = 4'h3;
  localparam logic [3:0] CMD_ERR_RST = 4'h4;
  localparam logic [3:0] CMD_BRKINT_RST = 4'h5;
  localparam logic [3:0] CMD_BRK_START = 4'h6;
  localparam logic [3:0] CMD_BRK_STOP = 4'h7;
  localparam logic [3:0] CMD_CT_START = 4'h8;
  localparam logic [3:0] CMD_CT_STOP = 4'h9;
  localparam logic [3:0] CMD_RTS_ON = 4'ha;
  localparam logic [3:0] CMD_RTS_OFF = 4'hb;
  localparam logic [3:0] CMD_MPIINT_RST = 4'hc;
  localparam int CR_TX_DIS = 3;
  localparam int CR_TX_EN = 2;
  localparam int CR_RX_DIS = 1;
  localparam int CR_RX_EN = 0;
  localparam int MR1_RXRTS = 7;
  localparam int MR1_RXINT = 6;
  localparam int MR1_ERRBLK = 5;
  localparam int MR1_PTYPE = 2;
  localparam int MR2_CTS = 4;
  localparam int MR2_STOP_HI = 3;
  localparam int ACR_NORMAL = 3;
  localparam logic [1:0] CHAN_NORMAL = 2'h0;
  localparam logic [1:0] CHAN_ECHO = 2'h1;
  localparam logic [1:0] CHAN_LOCAL = 2'h2;
  localparam logic [1:0] CHAN_REMOTE = 2'h3;
  localparam logic [1:0] PAR_WITH = 2'h0;
  localparam logic [1:0] PAR_NONE = 2'h2;
  localparam logic [1:0] PAR_SPECIAL = 2'h3;
  localparam logic [2:0] MPO_RTS = 3'h0;
  localparam logic [2:0] MPO_CT = 3'h1;
  localparam logic [2:0] MPO_TX1 = 3'h2;
  localparam logic [2:0] MPO_TX16 = 3'h3;
  localparam logic [2:0] MPO_RX1 = 3'h4;
  localparam logic [2:0] MPO_RX16 = 3'h5;
  localparam logic [2:0] MPO_TX_HOLDING_FREE = 3'h6;
  localparam logic [5:0] TICK_LAST = 6'h0f;
  localparam logic [5:0] TICK_HALF = 6'h07;
  localparam logic [5:0] STOP_SHORT_BASE = 6'h09;
  localparam logic [5:0] STOP_LONG_BASE = 6'h11;
  localparam logic [5:0] STOP_FIVE_ADD = 6'h08;
  localparam logic [7:0] MR_RST = 8'h00;
  localparam logic [7:0] CSR_RST = 8'h00;
  localparam logic [7:0] ACR_RST = 8'h08;
  localparam logic [7:0] IMR_RST = 8'h00;
  localparam logic [7:0] CT_RST = 8'h00;
  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } rx_entry_type;
  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} tx_state_type;
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} rx_state_type;
endpackage

//--- hdl/sync_fifo.sv
module sync_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_r, wrPtr_nxt, rdPtr_r, rdPtr_nxt;
  logic [CW-1:0] count_r, count_nxt;
  logic push, pop;

  assign inReady = (count_r != CW'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem[rdPtr_r];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always_comb begin
    wrPtr_nxt = push ? AW'((wrPtr_r + 1'b1) % DEPTH) : wrPtr_r;
    rdPtr_nxt = pop ? AW'((rdPtr_r + 1'b1) % DEPTH) : rdPtr_r;
    count_nxt = count_r + CW'(push) - CW'(pop);
    if (flush) begin
      wrPtr_nxt = '0;
      rdPtr_nxt = '0;
      count_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      wrPtr_r <= wrPtr_nxt;
      rdPtr_r <= rdPtr_nxt;
      count_r <= count_nxt;
    end
  end

  // Storage has no reset; only pointers and count matter
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem[wrPtr_r] <= inData;
    end
  end
endmodule

//--- hdl/uart_regs.sv
module uart_regs #(
  parameter int BAUD_DIV = 8,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [uart_regs_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  input wire logic rxd,
  output logic txd,
  input wire logic clearToSendInN,
  output logic multipurposeOutputPin,
  output logic irqN
);
  import uart_regs_pkg::*;

  logic [7:0] mr1_r, mr1_nxt, mr2_r, mr2_nxt, csr_r, csr_nxt, acr_r, acr_nxt;
  logic [7:0] imr_r, imr_nxt, ctHi_r, ctHi_nxt, ctLo_r, ctLo_nxt;
  logic [7:0] thr_r, thr_nxt, rdData_r, rdData_nxt;
  logic ptr_r, ptr_nxt, txEn_r, txEn_nxt, rxEn_r, rxEn_nxt;
  logic rtsOn_r, rtsOn_nxt, autoNeg_r, autoNeg_nxt, brkOn_r, brkOn_nxt;
  logic oe_r, oe_nxt, errMask_r, errMask_nxt, thrFull_r, thrFull_nxt;
  logic isrMpi_r, isrMpi_nxt, isrBrk_r, isrBrk_nxt, mpiPrev_r;
  logic [2:0] errAcc_r, errAcc_nxt, headErr, stFlags;
  tx_state_type txState_r, txState_nxt;
  rx_state_type rxState_r, rxState_nxt;
  logic [5:0] txCnt_r, txCnt_nxt, rxCnt_r, rxCnt_nxt, stopTicks;
  logic [2:0] txBit_r, txBit_nxt, rxBit_r, rxBit_nxt, charLast;
  logic [7:0] txShift_r, txShift_nxt, rxShift_r, rxShift_nxt;
  logic txPar_r, txPar_nxt, rxPar_r, rxPar_nxt, txLine, txd_r, txd_nxt;
  logic brkHold_r, brkHold_nxt, pendValid_r, pendValid_nxt;
  rx_entry_type pend_r, pend_nxt, head, newEntry;
  logic [15:0] divCnt_r, divCnt_nxt, ctCnt_r, ctCnt_nxt;
  logic tick, clk16_r, ctRun_r, ctRun_nxt, ctReady_r, ctReady_nxt, ctOut_r, ctOut_nxt;
  logic mpo_r, mpo_nxt, mpoSel;
  logic cmdWr, dataRd, pop, txLoad, txIdle, tx_holding_free, tx_fully_idle, rx_fifo_full_flag, rx_char_available, rxIsrSrc;
  logic rxIn, rxDone, rxStartOk, brkEdge, rxOvr, parOn, fifoInReady, fifoOutValid;
  logic [10:0] fifoOut;
  logic [7:0] status, interrupt_status;
  logic [1:0] chan;

  localparam logic [15:0] DIV_LAST = 16'(BAUD_DIV - 1);

  function automatic logic isCmd(input logic wr, input logic [7:0] d, input logic [3:0] c);
    return wr && (d[7:4] == c);
  endfunction

  function automatic logic parCalc(input logic [7:0] d, input logic [1:0] len,
                                   input logic [1:0] mode, input logic ptype);
    logic [7:0] dm;
    dm = d & (8'hff >> (~len));
    return (mode == PAR_WITH) ? (^dm ^ ptype) : ptype;
  endfunction

  assign chan = mr2_r[7:6];
  assign parOn = (mr1_r[4:3] != PAR_NONE);
  assign charLast = 3'h4 + {1'b0, mr1_r[1:0]};
  assign cmdWr = wrEn && (addr == OFS_CMD);
  assign dataRd = rdEn && (addr == OFS_DATA);
  assign head = rx_entry_type'(fifoOut);
  assign pop = dataRd && fifoOutValid;
  assign rx_fifo_full_flag = !fifoInReady;
  assign rx_char_available = fifoOutValid;
  assign rxIsrSrc = mr1_r[MR1_RXINT] ? rx_fifo_full_flag : rx_char_available;
  assign txIdle = (txState_r == TX_IDLE);
  // Echo steals the transmitter, so its ready flags drop
  assign tx_holding_free = txEn_r && !thrFull_r && (chan != CHAN_ECHO);
  assign tx_fully_idle = tx_holding_free && txIdle;
  // CTS sampled only here, so a change mid-character has no effect
  assign txLoad = tick && txIdle && thrFull_r && !brkOn_r &&
                  (!mr2_r[MR2_CTS] || !clearToSendInN);
  assign headErr = (fifoOutValid && !errMask_r) ? {head.brk, head.fe, head.pe} : 3'h0;
  assign stFlags = mr1_r[MR1_ERRBLK] ? (errAcc_r | headErr) : headErr;
  assign status = {stFlags, oe_r, tx_fully_idle, tx_holding_free, rx_fifo_full_flag, rx_char_available};
  assign interrupt_status = {isrMpi_r, clearToSendInN, 1'b0, ctReady_r, isrBrk_r, rxIsrSrc, tx_fully_idle, tx_holding_free};
  assign irqN = ~|(interrupt_status & imr_r);
  assign tick = acr_r[ACR_NORMAL] && (divCnt_r == DIV_LAST);
  assign rdData = rdData_r;
  assign txd = txd_r;
  assign multipurposeOutputPin = mpo_r;

  always_comb begin
    mr1_nxt = mr1_r;
    mr2_nxt = mr2_r;
    csr_nxt = csr_r;
    acr_nxt = acr_r;
    imr_nxt = imr_r;
    ctHi_nxt = ctHi_r;
    ctLo_nxt = ctLo_r;
    ptr_nxt = ptr_r;
    thr_nxt = thr_r;
    thrFull_nxt = thrFull_r && !txLoad;
    rdData_nxt = 8'h00;
    if (rdEn) begin
      if (addr == OFS_MODE) begin
        rdData_nxt = ptr_r ? mr2_r : mr1_r;
        ptr_nxt = 1'b1;
      end else if (addr == OFS_STAT) begin
        rdData_nxt = status;
      end else if (addr == OFS_DATA) begin
        rdData_nxt = head.data;
      end else if (addr == OFS_AUX) begin
        rdData_nxt = interrupt_status;
      end else if (addr == OFS_CTHI) begin
        rdData_nxt = ctHi_r;
      end else if (addr == OFS_CTLO) begin
        rdData_nxt = ctLo_r;
      end
    end
    if (wrEn) begin
      if (addr == OFS_MODE) begin
        if (ptr_r) begin
          mr2_nxt = wrData;
        end else begin
          mr1_nxt = wrData;
        end
        ptr_nxt = 1'b1;
      end else if (addr == OFS_STAT) begin
        csr_nxt = wrData;
      end else if (addr == OFS_DATA && txEn_r) begin
        thr_nxt = wrData;
        thrFull_nxt = 1'b1;
      end else if (addr == OFS_AUX) begin
        acr_nxt = wrData;
      end else if (addr == OFS_IMASK) begin
        imr_nxt = wrData;
      end else if (addr == OFS_CTHI) begin
        ctHi_nxt = wrData;
      end else if (addr == OFS_CTLO) begin
        ctLo_nxt = wrData;
      end
    end
    if (isCmd(cmdWr, wrData, CMD_PTR_RST)) begin
      ptr_nxt = 1'b0;
    end
    txEn_nxt = txEn_r;
    if (cmdWr && wrData[CR_TX_EN]) begin
      txEn_nxt = 1'b1;
    end else if (cmdWr && wrData[CR_TX_DIS]) begin
      txEn_nxt = 1'b0;
    end
    rxEn_nxt = rxEn_r;
    if (cmdWr && wrData[CR_RX_EN]) begin
      rxEn_nxt = 1'b1;
    end else if (cmdWr && wrData[CR_RX_DIS]) begin
      rxEn_nxt = 1'b0;
    end
    if (isCmd(cmdWr, wrData, CMD_TX_RST)) begin
      txEn_nxt = 1'b0;
      thrFull_nxt = 1'b0;
    end
    if (isCmd(cmdWr, wrData, CMD_RX_RST)) begin
      rxEn_nxt = 1'b0;
    end
    brkOn_nxt = brkOn_r;
    if (isCmd(cmdWr, wrData, CMD_BRK_START) && txEn_r) begin
      brkOn_nxt = 1'b1;
    end else if (isCmd(cmdWr, wrData, CMD_BRK_STOP)) begin
      brkOn_nxt = 1'b0;
    end
    rtsOn_nxt = rtsOn_r;
    autoNeg_nxt = autoNeg_r;
    if (isCmd(cmdWr, wrData, CMD_RTS_ON)) begin
      rtsOn_nxt = 1'b1;
    end else if (isCmd(cmdWr, wrData, CMD_RTS_OFF)) begin
      rtsOn_nxt = 1'b0;
    end
    if (mr1_r[MR1_RXRTS] && rxStartOk && rx_fifo_full_flag) begin
      rtsOn_nxt = 1'b0;
      autoNeg_nxt = 1'b1;
    end else if (autoNeg_r && !rx_fifo_full_flag) begin
      rtsOn_nxt = 1'b1;
      autoNeg_nxt = 1'b0;
    end
    // Flags: a new overrun, break or CTS change in the clearing cycle survives; errAcc_r clears regardless
    errAcc_nxt = errAcc_r | (mr1_r[MR1_ERRBLK] ? headErr : 3'h0);
    errMask_nxt = pop ? 1'b0 : errMask_r;
    oe_nxt = oe_r;
    if (isCmd(cmdWr, wrData, CMD_ERR_RST) || isCmd(cmdWr, wrData, CMD_RX_RST)) begin
      errAcc_nxt = 3'h0;
      // A flush empties the FIFO, so nothing is left to mask
      errMask_nxt = fifoOutValid && !pop && !isCmd(cmdWr, wrData, CMD_RX_RST);
      oe_nxt = 1'b0;
    end
    oe_nxt = oe_nxt || rxOvr;
    isrBrk_nxt = (isrBrk_r && !isCmd(cmdWr, wrData, CMD_BRKINT_RST)) || brkEdge;
    isrMpi_nxt = (isrMpi_r && !isCmd(cmdWr, wrData, CMD_MPIINT_RST)) ||
                 (mpiPrev_r != clearToSendInN);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mr1_r <= MR_RST;
      mr2_r <= MR_RST;
      csr_r <= CSR_RST;
      acr_r <= ACR_RST;
      imr_r <= IMR_RST;
      ctHi_r <= CT_RST;
      ctLo_r <= CT_RST;
      thr_r <= 8'h00;
      rdData_r <= 8'h00;
      {ptr_r, txEn_r, rxEn_r, rtsOn_r, autoNeg_r, brkOn_r} <= 6'h00;
      {oe_r, errMask_r, thrFull_r, isrMpi_r, isrBrk_r} <= 5'h00;
      mpiPrev_r <= 1'b1;
      errAcc_r <= 3'h0;
    end else begin
      mr1_r <= mr1_nxt;
      mr2_r <= mr2_nxt;
      csr_r <= csr_nxt;
      acr_r <= acr_nxt;
      imr_r <= imr_nxt;
      ctHi_r <= ctHi_nxt;
      ctLo_r <= ctLo_nxt;
      thr_r <= thr_nxt;
      rdData_r <= rdData_nxt;
      {ptr_r, txEn_r, rxEn_r, rtsOn_r, autoNeg_r, brkOn_r} <=
        {ptr_nxt, txEn_nxt, rxEn_nxt, rtsOn_nxt, autoNeg_nxt, brkOn_nxt};
      {oe_r, errMask_r, thrFull_r, isrMpi_r, isrBrk_r} <=
        {oe_nxt, errMask_nxt, thrFull_nxt, isrMpi_nxt, isrBrk_nxt};
      mpiPrev_r <= clearToSendInN;
      errAcc_r <= errAcc_nxt;
    end
  end

  always_comb begin
    stopTicks = {2'b00, mr2_r[3:0]} + (mr2_r[MR2_STOP_HI] ? STOP_LONG_BASE : STOP_SHORT_BASE);
    if (!mr2_r[MR2_STOP_HI] && mr1_r[1:0] == 2'b00) begin
      stopTicks = stopTicks + STOP_FIVE_ADD;
    end
    txState_nxt = txState_r;
    txCnt_nxt = txCnt_r;
    txBit_nxt = txBit_r;
    txShift_nxt = txShift_r;
    txPar_nxt = txPar_r;
    case (txState_r)
      TX_START: txLine = 1'b0;
      TX_DATA: txLine = txShift_r[0];
      TX_PAR: txLine = txPar_r;
      default: txLine = 1'b1;
    endcase
    if (isCmd(cmdWr, wrData, CMD_TX_RST)) begin
      txState_nxt = TX_IDLE;
    end else if (txLoad) begin
      txShift_nxt = thr_r;
      txPar_nxt = parCalc(thr_r, mr1_r[1:0], mr1_r[4:3], mr1_r[MR1_PTYPE]);
      txCnt_nxt = 6'h00;
      txState_nxt = TX_START;
    end else if (tick && !txIdle) begin
      txCnt_nxt = txCnt_r + 6'h01;
      if (txState_r == TX_STOP && txCnt_r == stopTicks - 6'h01) begin
        txState_nxt = TX_IDLE;
      end else if (txState_r != TX_STOP && txCnt_r == TICK_LAST) begin
        txCnt_nxt = 6'h00;
        txBit_nxt = 3'h0;
        if (txState_r == TX_START) begin
          txState_nxt = TX_DATA;
        end else if (txState_r == TX_DATA) begin
          txShift_nxt = {1'b0, txShift_r[7:1]};
          txBit_nxt = txBit_r + 3'h1;
          if (txBit_r == charLast) begin
            txState_nxt = parOn ? TX_PAR : TX_STOP;
          end
        end else begin
          txState_nxt = TX_STOP;
        end
      end
    end
    // Break only lands between characters
    if (chan == CHAN_LOCAL) begin
      txd_nxt = 1'b1;
    end else if (chan == CHAN_NORMAL) begin
      txd_nxt = txLine && !(brkOn_r && txIdle && !thrFull_r);
    end else begin
      txd_nxt = rxd;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txState_r <= TX_IDLE;
      txCnt_r <= 6'h00;
      txBit_r <= 3'h0;
      txShift_r <= 8'h00;
      txPar_r <= 1'b0;
      txd_r <= 1'b1;
    end else begin
      txState_r <= txState_nxt;
      txCnt_r <= txCnt_nxt;
      txBit_r <= txBit_nxt;
      txShift_r <= txShift_nxt;
      txPar_r <= txPar_nxt;
      txd_r <= txd_nxt;
    end
  end

  always_comb begin
    rxIn = (chan == CHAN_LOCAL) ? txLine : rxd;
    rxState_nxt = rxState_r;
    rxCnt_nxt = rxCnt_r + 6'h01;
    rxBit_nxt = rxBit_r;
    rxShift_nxt = rxShift_r;
    rxPar_nxt = rxPar_r;
    brkHold_nxt = brkHold_r;
    rxDone = 1'b0;
    rxStartOk = 1'b0;
    brkEdge = 1'b0;
    newEntry.data = rxShift_r >> (~mr1_r[1:0]);
    newEntry.fe = !rxIn;
    newEntry.brk = (newEntry.data == 8'h00) && !rxIn && !(parOn && rxPar_r);
    newEntry.pe = parOn && ((mr1_r[4:3] == PAR_SPECIAL) ? rxPar_r :
                  (rxPar_r != parCalc(newEntry.data, mr1_r[1:0], mr1_r[4:3],
                                      mr1_r[MR1_PTYPE])));
    if (!rxEn_r) begin
      rxState_nxt = RX_IDLE;
      rxCnt_nxt = rxCnt_r;
    end else if (!tick) begin
      rxCnt_nxt = rxCnt_r;
    end else begin
      case (rxState_r)
        RX_IDLE: begin
          rxCnt_nxt = 6'h00;
          // After a break the line must mark before a new start
          if (brkHold_r) begin
            if (rxIn) begin
              brkHold_nxt = 1'b0;
              brkEdge = 1'b1;
            end
          end else if (!rxIn) begin
            rxState_nxt = RX_START;
          end
        end
        RX_START: begin
          if (rxCnt_r == TICK_HALF) begin
            rxCnt_nxt = 6'h00;
            rxBit_nxt = 3'h0;
            rxState_nxt = rxIn ? RX_IDLE : RX_DATA;
            rxStartOk = !rxIn;
          end
        end
        RX_DATA: begin
          if (rxCnt_r == TICK_LAST) begin
            rxCnt_nxt = 6'h00;
            rxShift_nxt = {rxIn, rxShift_r[7:1]};
            rxBit_nxt = rxBit_r + 3'h1;
            if (rxBit_r == charLast) begin
              rxState_nxt = parOn ? RX_PAR : RX_STOP;
            end
          end
        end
        RX_PAR: begin
          if (rxCnt_r == TICK_LAST) begin
            rxCnt_nxt = 6'h00;
            rxPar_nxt = rxIn;
            rxState_nxt = RX_STOP;
          end
        end
        default: begin
          if (rxCnt_r == TICK_LAST) begin
            rxDone = 1'b1;
            rxState_nxt = RX_IDLE;
            brkHold_nxt = newEntry.brk;
            brkEdge = newEntry.brk;
          end
        end
      endcase
    end
    pendValid_nxt = pendValid_r && !fifoInReady;
    pend_nxt = pend_r;
    rxOvr = 1'b0;
    if (rxDone && chan != CHAN_REMOTE) begin
      if (pendValid_r && !fifoInReady) begin
        rxOvr = 1'b1;
      end else begin
        pend_nxt = newEntry;
        pendValid_nxt = 1'b1;
      end
    end
    if (isCmd(cmdWr, wrData, CMD_RX_RST)) begin
      pendValid_nxt = 1'b0;
      brkHold_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rxState_r <= RX_IDLE;
      rxCnt_r <= 6'h00;
      rxBit_r <= 3'h0;
      rxShift_r <= 8'h00;
      rxPar_r <= 1'b0;
      brkHold_r <= 1'b0;
      pendValid_r <= 1'b0;
      pend_r <= '0;
    end else begin
      rxState_r <= rxState_nxt;
      rxCnt_r <= rxCnt_nxt;
      rxBit_r <= rxBit_nxt;
      rxShift_r <= rxShift_nxt;
      rxPar_r <= rxPar_nxt;
      brkHold_r <= brkHold_nxt;
      pendValid_r <= pendValid_nxt;
      pend_r <= pend_nxt;
    end
  end

  sync_fifo #(.WIDTH($bits(rx_entry_type)), .DEPTH(FIFO_DEPTH)) rxFifo (
    .clk(clk),
    .rst_n(rst_n),
    .flush(isCmd(cmdWr, wrData, CMD_RX_RST)),
    .inValid(pendValid_r),
    .inReady(fifoInReady),
    .inData(pend_r),
    .outValid(fifoOutValid),
    .outReady(dataRd),
    .outData(fifoOut)
  );

  always_comb begin
    divCnt_nxt = acr_r[ACR_NORMAL] ? (tick ? 16'h0000 : divCnt_r + 16'h0001) : divCnt_r;
    ctCnt_nxt = ctCnt_r;
    ctRun_nxt = ctRun_r;
    ctOut_nxt = ctOut_r;
    ctReady_nxt = ctReady_r && !isCmd(cmdWr, wrData, CMD_CT_STOP);
    if (isCmd(cmdWr, wrData, CMD_CT_START)) begin
      ctCnt_nxt = {ctHi_r, ctLo_r};
      ctRun_nxt = 1'b1;
    end else if (ctRun_r) begin
      if (ctCnt_r == 16'h0000) begin
        ctCnt_nxt = {ctHi_r, ctLo_r};
        ctOut_nxt = !ctOut_r;
        ctReady_nxt = 1'b1;
      end else begin
        ctCnt_nxt = ctCnt_r - 16'h0001;
      end
    end
    case (acr_r[2:0])
      MPO_RTS: mpoSel = !rtsOn_r;
      MPO_CT: mpoSel = ctOut_r;
      MPO_TX1: mpoSel = txCnt_r[3];
      MPO_TX16: mpoSel = clk16_r;
      MPO_RX1: mpoSel = rxCnt_r[3];
      MPO_RX16: mpoSel = clk16_r;
      MPO_TX_HOLDING_FREE: mpoSel = tx_holding_free;
      default: mpoSel = rxIsrSrc;
    endcase
    mpo_nxt = mpoSel;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt_r <= 16'h0000;
      clk16_r <= 1'b0;
      ctCnt_r <= 16'h0000;
      ctRun_r <= 1'b0;
      ctReady_r <= 1'b0;
      ctOut_r <= 1'b1;
      mpo_r <= 1'b1;
    end else begin
      divCnt_r <= divCnt_nxt;
      clk16_r <= clk16_r ^ tick;
      ctCnt_r <= ctCnt_nxt;
      ctRun_r <= ctRun_nxt;
      ctReady_r <= ctReady_nxt;
      ctOut_r <= ctOut_nxt;
      mpo_r <= mpo_nxt;
    end
  end
endmodule

//--- dv/uart_regs_props.sv
module uart_regs_props (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [uart_regs_pkg::ADDR_W-1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  input wire logic txd,
  input wire logic multipurposeOutputPin,
  input wire logic irqN
);
  timeunit 1ns;
  timeprecision 1ps;
  import uart_regs_pkg::*;
  logic [7:0] hi_r, lo_r, mask_r;
  logic touched_r, txOn_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_r <= CT_RST;
      lo_r <= CT_RST;
      mask_r <= IMR_RST;
      touched_r <= 1'b0;
      txOn_r <= 1'b0;
    end else if (wrEn) begin
      if (addr == OFS_CTHI) hi_r <= wrData;
      if (addr == OFS_CTLO) lo_r <= wrData;
      if (addr == OFS_IMASK) mask_r <= wrData;
      if (addr == OFS_AUX || addr == OFS_CMD) touched_r <= 1'b1;
      if (addr == OFS_MODE || (addr == OFS_CMD && wrData[CR_TX_EN])) txOn_r <= 1'b1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence readOf(logic [2:0] a);
    rdEn && addr == a;
  endsequence
  a_read_idle_zero: assert property (!$past(rdEn) |-> rdData == 8'h00)
    else $error("read data outside slot");
  a_cmd_read_zero: assert property (readOf(OFS_CMD) |=> rdData == 8'h00)
    else $error("command read not zero");
  a_mask_read_zero: assert property (readOf(OFS_IMASK) |=> rdData == 8'h00)
    else $error("mask read not zero");
  a_preset_high_read: assert property (readOf(OFS_CTHI) |=> rdData == $past(hi_r))
    else $error("preset high mismatch");
  a_preset_low_read: assert property (readOf(OFS_CTLO) |=> rdData == $past(lo_r))
    else $error("preset low mismatch");
  a_irq_masked_off: assert property (mask_r == 8'h00 |-> irqN)
    else $error("interrupt with empty mask");
  a_tx_idle_disabled: assert property (!txOn_r |-> txd)
    else $error("line active before enable");
  a_mpo_reset_high: assert property (!touched_r |-> multipurposeOutputPin)
    else $error("output pin low after reset");
endmodule
bind uart_regs uart_regs_props u_props (.clk(clk), .rst_n(rst_n), .addr(addr),
  .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .txd(txd),
  .multipurposeOutputPin(multipurposeOutputPin), .irqN(irqN));

//--- dv/remote_serial.sv
module remote_serial #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk,
  output logic rxd,
  input wire logic txd
);
  timeunit 1ns;
  timeprecision 1ps;
  initial rxd = 1'b1;
  // Bad stop lasts 5/8 bit, so a false start re-check sees marking
  task automatic sendChar(input logic [7:0] d, input logic goodStop);
    logic [8:0] f;
    f = {d, 1'b0};
    for (int i = 0; i < 9; i++) begin
      rxd <= f[i];
      repeat (BIT_CLKS) @(posedge clk);
    end
    rxd <= goodStop;
    repeat (BIT_CLKS * 5 / 8) @(posedge clk);
    rxd <= 1'b1;
    repeat (BIT_CLKS * 2) @(posedge clk);
  endtask
  task automatic recvChar(output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    while (txd !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    repeat (BIT_CLKS / 2) @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CLKS) @(posedge clk);
      d[i] = txd;
    end
    repeat (BIT_CLKS) @(posedge clk);
    ok = n < 4000 && txd === 1'b1;
  endtask
endmodule

//--- dv/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import uart_regs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic clear_to_send_in = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wrData = 8'h00;
  logic multipurpose_output_pin, irqN, txd, rxd, ok;
  logic [7:0] rdData, got;
  int failCount = 0;
  int totalChecks = 0;
  uart_regs #(.BAUD_DIV(2), .FIFO_DEPTH(16)) u_dut (.clk(clk), .rst_n(rst_n), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rxd(rxd), .txd(txd),
    .clearToSendInN(clear_to_send_in), .multipurposeOutputPin(multipurpose_output_pin), .irqN(irqN));
  remote_serial #(.BIT_CLKS(32)) u_remote (.clk(clk), .rxd(rxd), .txd(txd));
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic tallyAndFinish();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
    totalChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wrData <= d;
    wrEn <= 1'b1;
    @(posedge clk);
    wrEn <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [2:0] a);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge clk);
    rdEn <= 1'b0;
    #1 got = rdData;
    @(posedge clk);
  endtask
  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string what);
    rd(a);
    chk(what, exp, got);
  endtask
  task automatic cmd(input logic [7:0] d);
    wr(OFS_CMD, d);
    repeat (2) @(posedge clk);
  endtask
  task automatic setModes(input logic [7:0] one, input logic [7:0] two);
    cmd(8'h10);
    wr(OFS_MODE, one);
    wr(OFS_MODE, two);
  endtask
  task automatic waitChar();
    for (int n = 0; n < 1500; n++) begin
      rd(OFS_STAT);
      if (got[0] === 1'b1) return;
    end
    chk("char wait", 8'h01, 8'h00);
    tallyAndFinish();
  endtask
  task automatic testRegs();
    rdChk(OFS_CTHI, CT_RST, "preset high reset");
    wr(OFS_CTHI, 8'ha5);
    wr(OFS_CTLO, 8'h3c);
    rdChk(OFS_CTHI, 8'ha5, "preset high");
    rdChk(OFS_CTLO, 8'h3c, "preset low");
    rdChk(OFS_CMD, 8'h00, "command read");
    setModes(8'h13, 8'h87);
    rdChk(OFS_MODE, 8'h87, "mode two");
    cmd(8'h10);
    rdChk(OFS_MODE, 8'h13, "mode one");
  endtask
  task automatic testLoop();
    wr(OFS_DATA, 8'h55);
    cmd(8'h05);
    wr(OFS_DATA, 8'h3c);
    waitChar();
    rdChk(OFS_DATA, 8'h3c, "looped char");
    rd(OFS_STAT);
    chk("extra char", 8'h00, got & 8'h01);
  endtask
  task automatic testCharErr();
    setModes(8'h13, 8'h07);
    u_remote.sendChar(8'h5a, 1'b0);
    waitChar();
    chk("head flags", 8'h40, got & 8'he0);
    rdChk(OFS_DATA, 8'h5a, "errored char");
    rd(OFS_STAT);
    chk("flags after pop", 8'h00, got & 8'he1);
  endtask
  task automatic testBlockErr();
    setModes(8'h33, 8'h07);
    u_remote.sendChar(8'h5a, 1'b0);
    u_remote.sendChar(8'h21, 1'b1);
    waitChar();
    rdChk(OFS_DATA, 8'h5a, "first block char");
    rd(OFS_STAT);
    chk("held flag", 8'h40, got & 8'he0);
    cmd(8'h40);
    rd(OFS_STAT);
    chk("flags after reset", 8'h00, got & 8'he0);
    rdChk(OFS_DATA, 8'h21, "second block char");
  endtask
  task automatic testCtsTx();
    setModes(8'h13, 8'h17);
    clear_to_send_in <= 1'b1;
    wr(OFS_DATA, 8'ha5);
    repeat (200) @(posedge clk);
    #1 chk("line while held", 8'h01, {7'h00, txd});
    @(posedge clk);
    clear_to_send_in <= 1'b0;
    u_remote.recvChar(got, ok);
    chk("sent char", 8'ha5, got);
    chk("stop seen", 8'h01, {7'h00, ok});
    if (!ok) begin
      tallyAndFinish();
    end
  endtask
  task automatic testEcho();
    setModes(8'h13, 8'h47);
    rd(OFS_STAT);
    chk("echo tx flags", 8'h00, got & 8'h0c);
    fork
      u_remote.sendChar(8'h5a, 1'b1);
      begin
        repeat (10) @(posedge clk);
        #1 chk("echo line", 8'h00, {7'h00, txd});
      end
    join
    waitChar();
    rdChk(OFS_DATA, 8'h5a, "echo char");
    setModes(8'h13, 8'hc7);
    u_remote.sendChar(8'h33, 1'b1);
    rd(OFS_STAT);
    chk("remote not stored", 8'h00, got & 8'h01);
  endtask
  task automatic testRts();
    setModes(8'h93, 8'h07);
    for (int i = 0; i < 16; i++) begin
      u_remote.sendChar(8'h41, 1'b1);
    end
    chk("rts before full", 8'h00, {7'h00, multipurpose_output_pin});
    u_remote.sendChar(8'h42, 1'b1);
    chk("rts when full", 8'h01, {7'h00, multipurpose_output_pin});
    rd(OFS_DATA);
    repeat (2) @(posedge clk);
    #1 chk("rts after pop", 8'h00, {7'h00, multipurpose_output_pin});
  endtask
  task automatic testPins();
    cmd(8'ha0);
    chk("pin rts on", 8'h00, {7'h00, multipurpose_output_pin});
    wr(OFS_AUX, 8'h0e);
    @(posedge clk);
    chk("pin tx ready", 8'h01, {7'h00, multipurpose_output_pin});
    wr(OFS_AUX, 8'h08);
    wr(OFS_IMASK, 8'h01);
    chk("irq on", 8'h00, {7'h00, irqN});
    wr(OFS_IMASK, 8'h00);
    chk("irq masked", 8'h01, {7'h00, irqN});
    rdChk(OFS_IMASK, 8'h00, "mask read");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    testRegs();
    testLoop();
    testCharErr();
    testBlockErr();
    testEcho();
    testCtsTx();
    testPins();
    testRts();
    tallyAndFinish();
  end
endmodule
